/* File: core/pbdsi_consts.vh */
// Constants for the push button diagnostic and status block
`ifndef PBDSI_CONSTS_VH
`define PBDSI_CONSTS_VH

// Register byte offsets
`define PBDSI_REG_STD_IN     8'h00
`define PBDSI_REG_STD_OUT    8'h04
`define PBDSI_REG_SAFE_IN    8'h08
`define PBDSI_REG_SAFE_OUT   8'h0c
`define PBDSI_REG_ADDR_SET   8'h10
`define PBDSI_REG_ADDR_CFG   8'h14
`define PBDSI_REG_DIAG       8'h18
`define PBDSI_REG_IRQ_STAT   8'h1c
`define PBDSI_REG_IRQ_MASK   8'h20
`define PBDSI_REG_FW_CFG     8'h24
`define PBDSI_REG_FW_LOADED  8'h28

// Diagnostic status byte codes
`define PBDSI_DIAG_FAULT     8'h80
`define PBDSI_DIAG_NOLINK1   8'h01
`define PBDSI_DIAG_NOLINK2   8'h02

// Fault detail byte codes
`define PBDSI_FLT_CPU        8'h01
`define PBDSI_FLT_SAFE_CPU   8'h02
`define PBDSI_FLT_TEMP90     8'h04
`define PBDSI_FLT_TEMP95     8'h0c
`define PBDSI_FLT_OVERVOLT   8'h10
`define PBDSI_FLT_UNDERVOLT  8'h20

// Field positions
`define PBDSI_YELLOW_BIT     6
`define PBDSI_ESTOP_LAMP_BIT 7
`define PBDSI_SAFE_ESTOP0    0
`define PBDSI_SAFE_ESTOP1    1
`define PBDSI_SAFE_KEYSW0    2
`define PBDSI_SAFE_KEYSW1    3
`define PBDSI_SAFE_YELLOW    4
`define PBDSI_DIAG_FW_INFO   16
`define PBDSI_IRQ_FAULT      0
`define PBDSI_IRQ_LINK       1
`define PBDSI_IRQ_FW         2
`define PBDSI_IRQ_IDENT      3

// Reset values
`define PBDSI_STD_OUT_RST    16'h0000
`define PBDSI_SAFE_OUT_RST   24'h000000
`define PBDSI_ADDR_CFG_RST   16'h0000
`define PBDSI_FW_CFG_RST     16'h0000
`define PBDSI_IRQ_MASK_RST   4'h0

// Timing
`define PBDSI_CLK_NS         100
`define PBDSI_TICK_NS        1000000
`define PBDSI_TICK_CYC       (`PBDSI_TICK_NS / `PBDSI_CLK_NS)
`define PBDSI_FAST_MS        200
`define PBDSI_SLOW_MS        500

`endif

/* File: core/pbdsi_core.v */
// Push button station diagnostics, process image and LED indication
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "pbdsi_consts.vh"

// Operation
// - Word shows address selected on switches
// - Word shows address from controller configuration
// - Any fault sets status 80h plus detail
// - Detail 01 main CPU, 02 safety CPU
// - Detail 04 above 90C, 0C above 95C
// - Detail 10 overvoltage, 20 undervoltage
// - Status bits 01/02 flag port link loss
// - No-link LEDs only when both links down
// - Zero address: LED1 200ms, LED6 500ms
// - Only highest priority error pattern shown
// - Identify blinks LEDs 1-5, overrides data
// - Firmware mismatch gives informational, non-error flag
// - Yellow button std bit 6, safe bit 4
// - E-stop safe bits 0-1, key switch 2-3
// - Two standard bytes each way, keys 1-9
// - Three safety bytes in and out
// - One diagnostic word in image
module pbdsi_core #(
  parameter ADDR_W   = 16,
  parameter FW_W     = 16,
  parameter TICK_CYC = `PBDSI_TICK_CYC
) (
  input  wire              core_clk,
  input  wire              reset,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [7:0]        paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire [8:0]        key_pin,
  input  wire [1:0]        estop_pin,
  input  wire [1:0]        keysw_pin,
  input  wire [ADDR_W-1:0] addr_sw_pin,
  input  wire              cpu_fail,
  input  wire              safe_cpu_fail,
  input  wire              temp_90,
  input  wire              temp_95,
  input  wire              over_volt,
  input  wire              under_volt,
  input  wire              link1_down,
  input  wire              link2_down,
  input  wire              no_station_name,
  input  wire              no_data_exch,
  input  wire              link_general_err,
  input  wire              identify_req,
  input  wire [FW_W-1:0]   fw_loaded,
  output reg  [5:0]        led,
  output reg               yellow_lamp,
  output reg  [23:0]       safe_out,
  output reg               irq
);

  localparam SYNC_W = 25 + ADDR_W;
  localparam [2:0] PAT_DATA   = 3'h0;
  localparam [2:0] PAT_NOLINK = 3'h1;
  localparam [2:0] PAT_NONAME = 3'h2;
  localparam [2:0] PAT_NOXCHG = 3'h3;
  localparam [2:0] PAT_GENERR = 3'h4;
  localparam [2:0] PAT_ADRMIS = 3'h5;
  localparam [2:0] PAT_ADRZER = 3'h6;
  localparam [2:0] PAT_IDENT  = 3'h7;
  localparam [31:0] FAST_HALF = `PBDSI_FAST_MS / 2;
  localparam [31:0] SLOW_HALF = `PBDSI_SLOW_MS / 2;

  wire [SYNC_W-1:0] async_in;
  reg  [SYNC_W-1:0] sync1_q;
  reg  [SYNC_W-1:0] sync2_q;

  wire [8:0]        keys;
  wire [1:0]        estop;
  wire [1:0]        keysw;
  wire [ADDR_W-1:0] addr_set;
  wire              f_cpu;
  wire              f_scpu;
  wire              f_t90;
  wire              f_t95;
  wire              f_ov;
  wire              f_uv;
  wire              nolink1;
  wire              nolink2;
  wire              noname;
  wire              noxchg;
  wire              generr;
  wire              ident;

  reg  [15:0]       std_out_q;
  reg  [ADDR_W-1:0] addr_cfg_q;
  reg  [FW_W-1:0]   fw_cfg_q;
  reg  [3:0]        irq_stat_q;
  reg  [3:0]        irq_stat_d;
  reg  [3:0]        irq_mask_q;
  reg               fault_any_q;
  reg               link_any_q;
  reg               fw_info_q;
  reg               ident_q;

  reg  [31:0]       tick_cnt_q;
  reg               tick_q;
  reg  [31:0]       fast_cnt_q;
  reg  [31:0]       slow_cnt_q;
  reg               blink_fast_q;
  reg               blink_slow_q;

  reg  [7:0]        diag_status;
  reg  [7:0]        fault_detail;
  reg  [2:0]        pat_sel;
  reg  [5:0]        led_d;
  reg  [31:0]       rd_data;
  reg               rd_hit;

  wire [15:0]       std_in;
  wire [23:0]       safe_in;
  wire              fault_any;
  wire              link_any;
  wire              fw_info;
  wire              wr_en;
  wire [3:0]        events;

  // Pin inputs through two flip-flops
  assign async_in = {key_pin, estop_pin, keysw_pin, addr_sw_pin, cpu_fail, safe_cpu_fail,
                     temp_90, temp_95, over_volt, under_volt, link1_down, link2_down,
                     no_station_name, no_data_exch, link_general_err, identify_req};

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sync1_q <= {SYNC_W{1'b0}};
      sync2_q <= {SYNC_W{1'b0}};
    end else begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
    end
  end

  assign {keys, estop, keysw, addr_set, f_cpu, f_scpu, f_t90, f_t95, f_ov, f_uv,
          nolink1, nolink2, noname, noxchg, generr, ident} = sync2_q;

  assign std_in = {7'h00, keys};

  assign safe_in = {19'h00000, keys[`PBDSI_YELLOW_BIT], keysw[1], keysw[0],
                    estop[1], estop[0]};

  always @* begin
    fault_detail = 8'h00;
    if (f_cpu) begin
      fault_detail = fault_detail | `PBDSI_FLT_CPU;
    end
    if (f_scpu) begin
      fault_detail = fault_detail | `PBDSI_FLT_SAFE_CPU;
    end
    if (f_t95) begin
      fault_detail = fault_detail | `PBDSI_FLT_TEMP95;
    end else if (f_t90) begin
      fault_detail = fault_detail | `PBDSI_FLT_TEMP90;
    end
    if (f_ov) begin
      fault_detail = fault_detail | `PBDSI_FLT_OVERVOLT;
    end
    if (f_uv) begin
      fault_detail = fault_detail | `PBDSI_FLT_UNDERVOLT;
    end
    diag_status = 8'h00;
    if (fault_detail != 8'h00) begin
      diag_status = diag_status | `PBDSI_DIAG_FAULT;
    end
    if (nolink1) begin
      diag_status = diag_status | `PBDSI_DIAG_NOLINK1;
    end
    if (nolink2) begin
      diag_status = diag_status | `PBDSI_DIAG_NOLINK2;
    end
  end

  assign fault_any = (fault_detail != 8'h00);
  assign link_any  = nolink1 | nolink2;
  assign fw_info   = (fw_cfg_q != fw_loaded);

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tick_cnt_q <= 32'h00000000;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == TICK_CYC - 1) begin
      tick_cnt_q <= 32'h00000000;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h00000001;
      tick_q     <= 1'b0;
    end
  end

  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      fast_cnt_q   <= 32'h00000000;
      slow_cnt_q   <= 32'h00000000;
      blink_fast_q <= 1'b0;
      blink_slow_q <= 1'b0;
    end else if (tick_q) begin
      if (fast_cnt_q == FAST_HALF - 1) begin
        fast_cnt_q   <= 32'h00000000;
        blink_fast_q <= ~blink_fast_q;
      end else begin
        fast_cnt_q <= fast_cnt_q + 32'h00000001;
      end
      if (slow_cnt_q == SLOW_HALF - 1) begin
        slow_cnt_q   <= 32'h00000000;
        blink_slow_q <= ~blink_slow_q;
      end else begin
        slow_cnt_q <= slow_cnt_q + 32'h00000001;
      end
    end
  end

  always @* begin
    pat_sel = PAT_DATA;
    if (nolink1 & nolink2) begin
      pat_sel = PAT_NOLINK;
    end else if (noname) begin
      pat_sel = PAT_NONAME;
    end else if (noxchg) begin
      pat_sel = PAT_NOXCHG;
    end else if (generr) begin
      pat_sel = PAT_GENERR;
    end else if (addr_cfg_q != addr_set) begin
      pat_sel = PAT_ADRMIS;
    end else if (addr_cfg_q == {ADDR_W{1'b0}}) begin
      pat_sel = PAT_ADRZER;
    end else if (ident) begin
      pat_sel = PAT_IDENT;
    end
  end

  // LED pattern per selection, LED1 at bit 0
  always @* begin
    case (pat_sel)
      PAT_NOLINK: led_d = {5'h01, blink_fast_q};
      PAT_NONAME: led_d = {5'h02, blink_fast_q};
      PAT_NOXCHG: led_d = {5'h08, blink_fast_q};
      PAT_GENERR: led_d = {5'h04, blink_fast_q};
      PAT_ADRMIS: led_d = {blink_fast_q, 4'h0, blink_fast_q};
      PAT_ADRZER: led_d = {blink_slow_q, 4'h0, blink_fast_q};
      PAT_IDENT:  led_d = {1'b0, {5{blink_slow_q}}};
      PAT_DATA:   led_d = {std_out_q[`PBDSI_ESTOP_LAMP_BIT], std_out_q[4:0]};
      default:    led_d = 6'h00;
    endcase
  end

  // Register read decode
  always @* begin
    rd_data = 32'h00000000;
    rd_hit  = 1'b1;
    case (paddr)
      `PBDSI_REG_STD_IN:    rd_data = {16'h0000, std_in};
      `PBDSI_REG_STD_OUT:   rd_data = {16'h0000, std_out_q};
      `PBDSI_REG_SAFE_IN:   rd_data = {8'h00, safe_in};
      `PBDSI_REG_SAFE_OUT:  rd_data = {8'h00, safe_out};
      `PBDSI_REG_ADDR_SET:  rd_data = {{(32-ADDR_W){1'b0}}, addr_set};
      `PBDSI_REG_ADDR_CFG:  rd_data = {{(32-ADDR_W){1'b0}}, addr_cfg_q};
      `PBDSI_REG_DIAG:      rd_data = {15'h0000, fw_info_q, fault_detail, diag_status};
      `PBDSI_REG_IRQ_STAT:  rd_data = {28'h0000000, irq_stat_q};
      `PBDSI_REG_IRQ_MASK:  rd_data = {28'h0000000, irq_mask_q};
      `PBDSI_REG_FW_CFG:    rd_data = {{(32-FW_W){1'b0}}, fw_cfg_q};
      `PBDSI_REG_FW_LOADED: rd_data = {{(32-FW_W){1'b0}}, fw_loaded};
      default: begin
        rd_data = 32'h00000000;
        rd_hit  = 1'b0;
      end
    endcase
  end

  // APB answer one cycle after setup
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_hit;
      if (psel & ~penable & ~pwrite) begin
        prdata <= rd_data;
      end
    end
  end

  assign wr_en = psel & penable & pready & pwrite & ~pslverr;

  // Writable registers
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      std_out_q  <= `PBDSI_STD_OUT_RST;
      safe_out   <= `PBDSI_SAFE_OUT_RST;
      addr_cfg_q <= `PBDSI_ADDR_CFG_RST;
      fw_cfg_q   <= `PBDSI_FW_CFG_RST;
      irq_mask_q <= `PBDSI_IRQ_MASK_RST;
    end else if (wr_en) begin
      case (paddr)
        `PBDSI_REG_STD_OUT:  std_out_q  <= pwdata[15:0];
        `PBDSI_REG_SAFE_OUT: safe_out   <= pwdata[23:0];
        `PBDSI_REG_ADDR_CFG: addr_cfg_q <= pwdata[ADDR_W-1:0];
        `PBDSI_REG_FW_CFG:   fw_cfg_q   <= pwdata[FW_W-1:0];
        `PBDSI_REG_IRQ_MASK: irq_mask_q <= pwdata[3:0];
        default:             irq_mask_q <= irq_mask_q;
      endcase
    end
  end

  // Rising edges of monitored conditions
  assign events = {ident & ~ident_q, fw_info & ~fw_info_q,
                   link_any & ~link_any_q, fault_any & ~fault_any_q};

  always @* begin
    irq_stat_d = irq_stat_q;
    if (wr_en && (paddr == `PBDSI_REG_IRQ_STAT)) begin
      irq_stat_d = irq_stat_q & ~pwdata[3:0];
    end
    irq_stat_d = irq_stat_d | events;
  end

  // Sticky status, outputs and edge history
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_stat_q  <= 4'h0;
      irq         <= 1'b0;
      fault_any_q <= 1'b0;
      link_any_q  <= 1'b0;
      fw_info_q   <= 1'b0;
      ident_q     <= 1'b0;
      led         <= 6'h00;
      yellow_lamp <= 1'b0;
    end else begin
      irq_stat_q  <= irq_stat_d;
      irq         <= |(irq_stat_d & irq_mask_q);
      fault_any_q <= fault_any;
      link_any_q  <= link_any;
      fw_info_q   <= fw_info;
      ident_q     <= ident;
      led         <= led_d;
      // yellow lamp from output bit 6
      yellow_lamp <= std_out_q[`PBDSI_YELLOW_BIT];
    end
  end

endmodule // pbdsi_core

/* File: sim/pbdsi_props.sv */
// Port checker for the push button diagnostic and status block
`timescale 1ns/100ps
module pbdsi_props (
  input wire        core_clk,
  input wire        reset,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        link1_down,
  input wire        link2_down,
  input wire [5:0]  led
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_pready_next: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_pready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmapped_err: assert property (pready && paddr > 8'h28 |-> pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (pready && paddr <= 8'h28 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  a_unmapped_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_prdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed without read");
  a_nolink_led2: assert property ((link1_down && link2_down) [*6] |-> led[1])
    else $error("no-link LED2 not lit");
  a_nolink_rest: assert property ((link1_down && link2_down) [*6] |-> led[5:2] == 4'h0)
    else $error("no-link LEDs 3 to 6 not dark");
endmodule // pbdsi_props

bind pbdsi_core pbdsi_props u_pbdsi_props (
  .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .link1_down(link1_down), .link2_down(link2_down), .led(led));

/* File: sim/pbdsi_apb_host.sv */
// Controller model acting as APB master on the register port
`timescale 1ns/100ps
module pbdsi_apb_host (
  input  wire        core_clk,
  output reg         psel,
  output reg         penable,
  output reg         pwrite,
  output reg  [7:0]  paddr,
  output reg  [31:0] pwdata,
  input  wire [31:0] prdata,
  input  wire        pready,
  input  wire        pslverr
);
  initial {psel, penable, pwrite, paddr, pwdata} = 43'h0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released bus shows no stale values
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // pbdsi_apb_host

/* File: sim/pbdsi_core_tb.sv */
// Self-checking bench of the push button diagnostic and status block
`timescale 1ns/100ps
`include "pbdsi_consts.vh"
module pbdsi_core_tb;
  localparam int TK   = 2;
  localparam int FAST = `PBDSI_FAST_MS / 2 * TK;
  localparam int SLOW = `PBDSI_SLOW_MS / 2 * TK;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, yellow_lamp, irq, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, r;
  logic [8:0]  keys = 9'h0;
  logic [1:0]  es = 2'h0, ks = 2'h0, lnk = 2'h0;
  logic [15:0] asw = 16'h0, fwl = 16'h0;
  logic [5:0]  flt = 6'h0, led;
  logic [3:0]  ev = 4'h0;
  logic [23:0] safe_out;
  int          err_total = 0, num_checks = 0, n;
  integer      seed = 32'h5aa071c5;
  int          offs [5] = '{`PBDSI_REG_STD_OUT, `PBDSI_REG_SAFE_OUT, `PBDSI_REG_ADDR_CFG,
                            `PBDSI_REG_IRQ_MASK, `PBDSI_REG_FW_CFG};
  int          mask [5] = '{'hffff, 'hffffff, 'hffff, 'hf, 'hffff};
  int          codes [6] = '{1, 2, 4, 12, 16, 32};
  logic [4:0]  pri [3] = '{5'b00010, 5'b01000, 5'b00100};
  always #50 core_clk = ~core_clk;
  pbdsi_apb_host u_pbdsi_apb_host (.core_clk(core_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  pbdsi_core #(.TICK_CYC(TK)) u_pbdsi_core (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .key_pin(keys), .estop_pin(es), .keysw_pin(ks), .addr_sw_pin(asw),
    .cpu_fail(flt[0]), .safe_cpu_fail(flt[1]), .temp_90(flt[2]), .temp_95(flt[3]),
    .over_volt(flt[4]), .under_volt(flt[5]), .link1_down(lnk[0]), .link2_down(lnk[1]),
    .no_station_name(ev[0]), .no_data_exch(ev[1]), .link_general_err(ev[2]),
    .identify_req(ev[3]), .fw_loaded(fwl), .led(led), .yellow_lamp(yellow_lamp),
    .safe_out(safe_out), .irq(irq));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Rule model of the diagnostic word
  function automatic logic [31:0] diag_model(input logic [5:0] f, input logic [1:0] l);
    int d;
    d = 0;
    for (int i = 0; i < 6; i++) begin
      if (f[i]) d = d | codes[i];
    end
    return {16'h0, d[7:0], (d != 0) ? 8'h80 : 8'h00} | l;
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic xe, input string nm);
    u_pbdsi_apb_host.xfer(w, a, d, q, e);
    chk({nm, " response"}, {31'h0, e}, {31'h0, xe});
    if (!w) chk(nm, q, exp);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // Counts cycles between two LED changes
  task automatic half(input int b, input int exp, input string nm);
    logic v;
    repeat (2) begin
      n = 0;
      v = led[b];
      while (led[b] === v && n < 2000) begin
        cyc(1);
        n++;
      end
    end
    chk(nm, n, exp);
  endtask
  initial begin
    #3000000;
    chk("watchdog", 1, 0);
    tally_and_finish();
  end
  initial begin
    cyc(4);
    reset <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      bus(0, 8'(offs[i]), 0, 0, 0, "reset value");
      r = $random(seed) & mask[i];
      bus(1, 8'(offs[i]), r, 0, 0, "");
      bus(0, 8'(offs[i]), 0, r, 0, "read back");
    end
    bus(1, `PBDSI_REG_FW_CFG, 0, 0, 0, "");
    repeat (4) begin
      r = $random(seed);
      {keys, es, ks, asw} <= r[28:0];
      cyc(5);
      bus(1, `PBDSI_REG_STD_IN, ~r, 0, 0, "");
      bus(0, `PBDSI_REG_STD_IN, 0, {23'h0, keys}, 0, "std in"); // keys
      bus(0, `PBDSI_REG_SAFE_IN, 0, {27'h0, keys[6], ks, es}, 0, "safe in"); // bits
      bus(0, `PBDSI_REG_ADDR_SET, 0, {16'h0, asw}, 0, "addr set"); // switches
    end
    asw <= 16'h0018;
    bus(1, `PBDSI_REG_ADDR_CFG, 16'h0018, 0, 0, "");
    bus(0, `PBDSI_REG_ADDR_CFG, 0, 16'h0018, 0, "addr cfg"); // configured
    r = $random(seed);
    bus(1, `PBDSI_REG_STD_OUT, r, 0, 0, "");
    bus(1, `PBDSI_REG_SAFE_OUT, r >> 8, 0, 0, "");
    cyc(5);
    chk("yellow lamp", yellow_lamp, r[6]); // lamp
    chk("led data", led, {r[7], r[4:0]}); // lamps
    chk("safe out", safe_out, r[31:8]); // safety bytes
    for (int i = 0; i < 7; i++) begin
      flt <= (i < 6) ? 6'(1 << i) : 6'h3c;
      cyc(5);
      bus(0, `PBDSI_REG_DIAG, 0, diag_model(flt, lnk), 0, "fault");
    end
    flt <= 6'h0;
    for (int i = 0; i < 2; i++) begin
      lnk <= 2'h1 << i;
      cyc(5);
      bus(0, `PBDSI_REG_DIAG, 0, diag_model(flt, lnk), 0, "link status"); // port
      chk("one link led", led, {r[7], r[4:0]}); // both needed
    end
    lnk <= 2'h0;
    bus(1, `PBDSI_REG_IRQ_STAT, 32'hf, 0, 0, "");
    bus(1, `PBDSI_REG_IRQ_MASK, 32'h1, 0, 0, "");
    cyc(2);
    chk("irq idle", irq, 0);
    flt <= 6'h1;
    cyc(5);
    chk("irq raised", irq, 1);
    bus(0, `PBDSI_REG_IRQ_STAT, 0, 32'h1, 0, "irq status");
    bus(1, `PBDSI_REG_IRQ_MASK, 32'h0, 0, 0, "");
    cyc(2);
    chk("irq masked", irq, 0);
    bus(1, `PBDSI_REG_IRQ_MASK, 32'h1, 0, 0, "");
    bus(1, `PBDSI_REG_IRQ_STAT, 32'h1, 0, 0, "");
    cyc(2);
    chk("irq cleared", irq, 0);
    bus(0, `PBDSI_REG_IRQ_STAT, 0, 32'h0, 0, "irq status");
    flt <= 6'h0;
    bus(1, `PBDSI_REG_FW_CFG, 16'h0100, 0, 0, "");
    cyc(5);
    bus(0, `PBDSI_REG_DIAG, 0, 32'h10000, 0, "fw info"); // info only
    bus(0, 8'h40, 0, 0, 1, "unmapped");
    lnk <= 2'h3;
    ev <= 4'h1;
    cyc(6);
    chk("no link leds", led[5:1], 5'b00001); // top
    half(0, FAST, "no link blink"); // cycle
    lnk <= 2'h0;
    for (int i = 0; i < 3; i++) begin
      ev <= 4'(3'h7 << i);
      cyc(5);
      chk("priority leds", led[5:1], pri[i]); // order
      half(0, FAST, "error blink"); // cycle
    end
    ev <= 4'h0;
    bus(1, `PBDSI_REG_ADDR_CFG, 16'h0019, 0, 0, "");
    cyc(5);
    chk("mismatch leds", led[4:1], 4'h0); // pattern
    half(5, FAST, "mismatch blink"); // cycle
    asw <= 16'h0;
    bus(1, `PBDSI_REG_ADDR_CFG, 16'h0, 0, 0, "");
    cyc(5);
    chk("zero addr leds", led[4:1], 4'h0); // others off
    half(0, FAST, "zero addr led1"); // fast
    half(5, SLOW, "zero addr led6"); // slow
    asw <= 16'h0018;
    bus(1, `PBDSI_REG_ADDR_CFG, 16'h0018, 0, 0, "");
    ev <= 4'h8;
    cyc(5);
    half(0, SLOW, "identify blink"); // cycle
    cyc(led[0] ? 1 : SLOW + 1);
    chk("identify phase", led, 6'h1f); // in phase
    tally_and_finish();
  end
endmodule // pbdsi_core_tb
